// ### inc/monitor_pkg.sv
package monitor_pkg;

    // ==========================================================
    // Value widths and full scale
    // ==========================================================
    localparam int         VAL_W      = 10;
    localparam int         FREQ_W     = 16;
    localparam int         GAIN_W     = 8;
    localparam int         OFS_W      = 8;
    localparam int         SEL_W      = 3;
    localparam logic [9:0] FULL_SCALE = 10'h3FF;
    localparam logic [9:0] ZERO_VAL   = 10'h000;

    // ==========================================================
    // Source select codes
    // ==========================================================
    localparam logic [2:0] SEL_OUT_FREQ    = 3'h0;
    localparam logic [2:0] SEL_OUT_CURRENT = 3'h1;
    localparam logic [2:0] SEL_FREQ_PULSE  = 3'h3;
    localparam logic [2:0] SEL_OUT_VOLTAGE = 3'h4;
    localparam logic [2:0] SEL_IN_POWER    = 3'h5;
    localparam logic [2:0] SEL_THERMAL     = 3'h6;
    localparam logic [2:0] SEL_SOFT_FREQ   = 3'h7;

    // ==========================================================
    // Gain and offset scaling
    // ==========================================================
    // A gain of 128 passes the value unchanged.
    localparam int          GAIN_SHIFT          = 7;
    localparam logic [7:0]  DUTY_GAIN_DEFAULT   = 8'h80;
    localparam logic [7:0]  VOLT_GAIN_DEFAULT   = 8'hB4;
    localparam logic [7:0]  CURR_GAIN_DEFAULT   = 8'h50;
    localparam logic [7:0]  VOLT_OFS_DEFAULT    = 8'h00;
    localparam logic [7:0]  CURR_OFS_DEFAULT    = 8'h00;
    // Offsets are in 0.1 V and 0.1 mA steps; the multiplier maps one
    // step to output codes in units of 1/64 code.
    localparam int          OFS_SHIFT           = 6;
    localparam logic [10:0] VOLT_OFS_MUL        = 11'h28F;
    localparam logic [10:0] CURR_OFS_MUL        = 11'h199;
    localparam logic [10:0] NO_OFS_MUL          = 11'h000;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int         CLK_MHZ       = 100;
    localparam longint     CLK_HZ        = 100_000_000;
    localparam int         PWM_STEP_NS   = 150;
    localparam int         PWM_STEP_CYC  = (PWM_STEP_NS * CLK_MHZ + 999)
                                           / 1000;
    localparam logic [3:0] PWM_TICK_LAST = 4'(PWM_STEP_CYC - 1);
    localparam logic [9:0] PWM_CNT_LAST  = 10'h3FE;

    // Frequencies are in 0.01 Hz steps. The pulse pin toggles each
    // time the accumulator passes half an output cycle's worth of phase.
    localparam longint      FREQ_PER_HZ = 100;
    localparam int          FM_ACC_W    = 34;
    localparam longint      FM_MOD_L    = CLK_HZ * FREQ_PER_HZ / 2;
    localparam logic [33:0] FM_MODULUS  = FM_MOD_L[33:0];

    // ==========================================================
    // Divider
    // ==========================================================
    localparam logic [3:0] DIV_STEPS = 4'hA;

endpackage

// ### verif/coil_meter.sv
`timescale 1ns/100ps
module coil_meter
#(
    parameter int FRAME = 15345
)
(
    input  wire logic mclk_i,
    input  wire logic pin_i,
    input  wire logic start_i,
    output logic      done_o,
    output int        high_o
);
    initial {done_o, high_o} = '0;
    always @(posedge start_i) begin
        done_o = 1'b0;
        high_o = 0;
        repeat (FRAME) begin
            @(posedge mclk_i);
            if (pin_i === 1'b1) high_o++;
        end
        done_o = 1'b1;
    end
endmodule

// ### verif/monitor_chk.sv
`timescale 1ns/100ps
module monitor_chk
    import monitor_pkg::*;
(
    input wire logic              mclk_i,
    input wire logic              resetn_i,
    input wire logic [FREQ_W-1:0] out_freq_i,
    input wire logic [VAL_W-1:0]  out_current_i,
    input wire logic [VAL_W-1:0]  thermal_ratio_i,
    input wire logic [SEL_W-1:0]  digital_monitor_select_i,
    input wire logic [SEL_W-1:0]  voltage_out_select_i,
    input wire logic [GAIN_W-1:0] voltage_out_gain_i,
    input wire logic [OFS_W-1:0]  voltage_out_offset_i,
    input wire logic [SEL_W-1:0]  current_out_select_i,
    input wire logic [GAIN_W-1:0] current_out_gain_i,
    input wire logic [OFS_W-1:0]  current_out_offset_i,
    input wire logic              digital_monitor_pin_o,
    input wire logic              pulse_mode_o,
    input wire logic              select_error_o,
    input wire logic [VAL_W-1:0]  voltage_monitor_out_o,
    input wire logic [VAL_W-1:0]  current_loop_out_o
);
    // ==========================================================
    // Selects, scaling and the pulse pin
    // ==========================================================
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic bad_ana;
    assign bad_ana = voltage_out_select_i inside {3'h2, SEL_FREQ_PULSE} ||
                     current_out_select_i inside {3'h2, SEL_FREQ_PULSE};
    function automatic logic [9:0] scl(logic [9:0] v, logic [7:0] g,
                                       logic [7:0] o, logic [10:0] m);
        logic [19:0] s;
        s = ((v * g) >> GAIN_SHIFT) + ((o * m) >> OFS_SHIFT);
        return (s > 20'h003FF) ? FULL_SCALE : s[9:0];
    endfunction
    property p_pulse_on;
        digital_monitor_select_i == SEL_FREQ_PULSE |=> pulse_mode_o;
    endproperty
    a_pulse_on: assert property (p_pulse_on)
        else $error("pulse mode not entered");
    property p_pulse_off;
        digital_monitor_select_i != SEL_FREQ_PULSE |=> !pulse_mode_o;
    endproperty
    a_pulse_off: assert property (p_pulse_off)
        else $error("pulse mode outside code 3");
    property p_dig_err;
        digital_monitor_select_i == 3'h2 |=> select_error_o;
    endproperty
    a_dig_err: assert property (p_dig_err)
        else $error("digital code 2 not flagged");
    property p_ana_err;
        bad_ana |=> select_error_o;
    endproperty
    a_ana_err: assert property (p_ana_err)
        else $error("analog code not flagged");
    property p_no_err;
        digital_monitor_select_i != 3'h2 && !bad_ana |=> !select_error_o;
    endproperty
    a_no_err: assert property (p_no_err)
        else $error("error flag on valid codes");
    property p_volt_scale;
        (voltage_out_select_i == SEL_OUT_CURRENT && $stable({out_current_i,
         voltage_out_gain_i, voltage_out_offset_i}))[*3] |->
        voltage_monitor_out_o == scl(out_current_i, voltage_out_gain_i,
                                     voltage_out_offset_i, VOLT_OFS_MUL);
    endproperty
    a_volt_scale: assert property (p_volt_scale)
        else $error("voltage channel value wrong");
    property p_curr_scale;
        (current_out_select_i == SEL_THERMAL && $stable({thermal_ratio_i,
         current_out_gain_i, current_out_offset_i}))[*3] |->
        current_loop_out_o == scl(thermal_ratio_i, current_out_gain_i,
                                  current_out_offset_i, CURR_OFS_MUL);
    endproperty
    a_curr_scale: assert property (p_curr_scale)
        else $error("current channel value wrong");
    property p_pin_hold;
        (pulse_mode_o && out_freq_i == '0)[*4] |->
        $stable(digital_monitor_pin_o);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("pulse pin moved at zero frequency");
    c_pulse: cover property (pulse_mode_o);
    c_err: cover property (select_error_o);
    c_pwm: cover property ($rose(digital_monitor_pin_o) && !pulse_mode_o);
endmodule

bind drive_monitor_output_generator monitor_chk chk (.*);

// ### verif/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    errors++; $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
    end end
module tb
    import monitor_pkg::*;
;
    // ==========================================================
    // Stimulus and checking
    // ==========================================================
    localparam int FRAME = 1023 * PWM_STEP_CYC;
    typedef struct {int which; logic [15:0] exp;} note_t;
    logic clk = 1'b0, rstn = 1'b0, mstart = 1'b0, mdone, pin, pmode, serr;
    logic [15:0] ofreq, sfreq, maxf;
    logic [9:0] cur, vlt, pwr, thr, vout, cout;
    logic [2:0] dsel, vsel, csel;
    logic [7:0] dgain, vgain, vofs, cgain, cofs;
    logic [2:0] vsl[4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    logic [2:0] dsl[7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int mhigh, errors = 0, n_tests = 0;
    note_t q[$];
    event chk;
    always #5 clk = ~clk;
    drive_monitor_output_generator uut (
        .mclk_i(clk), .resetn_i(rstn), .out_freq_i(ofreq),
        .soft_start_freq_i(sfreq), .max_frequency_setting_i(maxf),
        .out_current_i(cur), .out_voltage_i(vlt), .in_power_i(pwr),
        .thermal_ratio_i(thr), .digital_monitor_select_i(dsel),
        .duty_gain_setting_i(dgain), .voltage_out_select_i(vsel),
        .voltage_out_gain_i(vgain), .voltage_out_offset_i(vofs),
        .current_out_select_i(csel), .current_out_gain_i(cgain),
        .current_out_offset_i(cofs), .digital_monitor_pin_o(pin),
        .pulse_mode_o(pmode), .select_error_o(serr),
        .voltage_monitor_out_o(vout), .current_loop_out_o(cout));
    coil_meter #(.FRAME(FRAME)) meter (.mclk_i(clk), .pin_i(pin),
        .start_i(mstart), .done_o(mdone), .high_o(mhigh));
    function automatic logic [9:0] ratio(logic [15:0] f);
        if (f >= maxf) return FULL_SCALE;
        return 10'((32'(f) << 10) / maxf);
    endfunction
    function automatic logic [9:0] src(logic [2:0] s);
        case (s)
            SEL_OUT_FREQ: return ratio(ofreq);
            SEL_OUT_CURRENT: return cur;
            SEL_OUT_VOLTAGE: return vlt;
            SEL_IN_POWER: return pwr;
            SEL_THERMAL: return thr;
            SEL_SOFT_FREQ: return ratio(sfreq);
            default: return ZERO_VAL;
        endcase
    endfunction
    function automatic logic [15:0] scl(logic [9:0] v, logic [7:0] g,
                                        logic [7:0] o, logic [10:0] m);
        logic [19:0] s;
        s = ((v * g) >> GAIN_SHIFT) + ((o * m) >> OFS_SHIFT);
        return (s > 20'h003FF) ? 16'h03FF : 16'(s);
    endfunction
    task automatic check_analog(input logic [2:0] vs, cs, input int lat);
        logic e;
        @(negedge clk);
        vsel = vs;
        csel = cs;
        e = dsel == 3'h2 || vs inside {3'h2, 3'h3} || cs inside {3'h2, 3'h3};
        repeat (lat) @(negedge clk);
        q.push_back('{0, scl(src(vs), vgain, vofs, VOLT_OFS_MUL)});
        q.push_back('{1, scl(src(cs), cgain, cofs, CURR_OFS_MUL)});
        q.push_back('{2, 16'(e)});
        q.push_back('{3, 16'(dsel == SEL_FREQ_PULSE)});
        -> chk;
    endtask
    task automatic check_pwm(input logic [9:0] v, input logic [7:0] g);
        logic [19:0] d;
        dsel = SEL_OUT_CURRENT;
        cur = v;
        dgain = g;
        d = (v * g) >> GAIN_SHIFT;
        if (d > 20'h003FF) d = 20'h003FF;
        repeat (FRAME + 20) @(negedge clk);
        mstart = 1'b1;
        @(negedge clk);
        mstart = 1'b0;
        wait (mdone);
        q.push_back('{4, 16'(d * PWM_STEP_CYC)});
        -> chk;
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(chk) begin
        note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.which)
                0: `CHK(16'(vout), n.exp)
                1: `CHK(16'(cout), n.exp)
                2: `CHK(16'(serr), n.exp)
                3: `CHK(16'(pmode), n.exp)
                default: `CHK(16'(mhigh), n.exp)
            endcase
        end
    end
    initial begin
        #700_000;
        errors++;
        wrap_up();
    end
    initial begin
        {ofreq, sfreq, maxf, cur, vlt, pwr, thr} = '0;
        {dsel, vsel, csel, dgain, vofs, cofs} = '0;
        vgain = VOLT_GAIN_DEFAULT;
        cgain = CURR_GAIN_DEFAULT;
        void'($urandom(2));
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 28; i++) begin
            @(negedge clk);
            {cur, vlt, pwr, thr} = 40'($urandom) ^ 40'($urandom) << 8;
            {vgain, cgain, dgain} = 24'($urandom);
            vofs = 8'($urandom_range(100));
            cofs = 8'($urandom_range(200));
            dsel = dsl[i % 7];
            check_analog(vsl[i % 4], vsl[3 - i % 4], 3);
        end
        cur = 10'h3FF;
        vgain = 8'hFF;
        check_analog(SEL_OUT_CURRENT, SEL_OUT_CURRENT, 3);
        {vgain, cgain, vofs, cofs} = {8'h80, 8'h80, 16'h0000};
        {maxf, ofreq, sfreq} = {16'h9C40, 16'h9C40, 16'h4E20};
        check_analog(SEL_OUT_FREQ, SEL_SOFT_FREQ, 40);
        dsel = 3'h2;
        check_analog(SEL_FREQ_PULSE, 3'h2, 3);
        check_pwm(10'h258, 8'h40);
        check_pwm(10'h3FF, 8'hFF);
        wrap_up();
    end
endmodule

// ### verilog/drive_monitor_output_generator.sv
// How it works
// (RULE_01) Digital source picked by select code
// (RULE_02) Code 03 pulses, all others PWM
// (RULE_03) Duty is high time over period
// (RULE_04) PWM duty multiplied by 8-bit gain
// (RULE_05) Pulse frequency follows inverter output frequency
// (RULE_06) Full scale pulse rate equals max frequency
// (RULE_07) Pulse mode digital, gain setting ignored
// (RULE_08) Analog channels have independent source selects
// (RULE_09) Voltage spans 0-10 V, current 4-20 mA
// (RULE_10) Each analog channel has gain and offset
// (RULE_11) Scaled values clip at full scale
`timescale 1ns/100ps

module drive_monitor_output_generator
    import monitor_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic [FREQ_W-1:0] out_freq_i,
    input  wire logic [FREQ_W-1:0] soft_start_freq_i,
    input  wire logic [FREQ_W-1:0] max_frequency_setting_i,
    input  wire logic [VAL_W-1:0]  out_current_i,
    input  wire logic [VAL_W-1:0]  out_voltage_i,
    input  wire logic [VAL_W-1:0]  in_power_i,
    input  wire logic [VAL_W-1:0]  thermal_ratio_i,
    input  wire logic [SEL_W-1:0]  digital_monitor_select_i,
    input  wire logic [GAIN_W-1:0] duty_gain_setting_i,
    input  wire logic [SEL_W-1:0]  voltage_out_select_i,
    input  wire logic [GAIN_W-1:0] voltage_out_gain_i,
    input  wire logic [OFS_W-1:0]  voltage_out_offset_i,
    input  wire logic [SEL_W-1:0]  current_out_select_i,
    input  wire logic [GAIN_W-1:0] current_out_gain_i,
    input  wire logic [OFS_W-1:0]  current_out_offset_i,
    output logic                   digital_monitor_pin_o,
    output logic                   pulse_mode_o,
    output logic                   select_error_o,
    output logic [VAL_W-1:0]       voltage_monitor_out_o,
    output logic [VAL_W-1:0]       current_loop_out_o
);

    // ==========================================================
    // Source mapping
    // ==========================================================
    logic [VAL_W-1:0] freq_frac;
    logic [VAL_W-1:0] soft_frac;

    // Codes outside the list give zero so a miswired setting reads
    // as an idle meter rather than a stale value.
    function automatic logic [VAL_W-1:0] pick_source(
        input logic [SEL_W-1:0] code,
        input logic             allow_pulse
    );
        logic [VAL_W-1:0] val;
        val = ZERO_VAL;
        case (code)
            SEL_OUT_FREQ:    val = freq_frac;
            SEL_OUT_CURRENT: val = out_current_i;
            SEL_FREQ_PULSE:  val = allow_pulse ? freq_frac : ZERO_VAL;
            SEL_OUT_VOLTAGE: val = out_voltage_i;
            SEL_IN_POWER:    val = in_power_i;
            SEL_THERMAL:     val = thermal_ratio_i;
            SEL_SOFT_FREQ:   val = soft_frac;
            default:         val = ZERO_VAL;
        endcase
        return val;
    endfunction

    function automatic logic code_ok(
        input logic [SEL_W-1:0] code,
        input logic             allow_pulse
    );
        logic ok;
        ok = 1'b1;
        case (code)
            SEL_FREQ_PULSE: ok = allow_pulse;
            3'h2:           ok = 1'b0;
            default:        ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ==========================================================
    // Frequency ratios, shared divider
    // ==========================================================
    logic             div_kick;
    logic             next_div_kick;
    logic             div_sel;
    logic             next_div_sel;
    logic             div_done;
    logic [VAL_W-1:0] div_quot;
    logic [VAL_W-1:0] next_freq_frac;
    logic [VAL_W-1:0] next_soft_frac;
    logic [FREQ_W-1:0] div_num;

    // One divider serves both frequencies in turn; the ratios lag by
    // a few dozen cycles, far below what a meter can show.
    assign div_num = div_sel ? soft_start_freq_i : out_freq_i;

    frac_divider u_div (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .start_i  (div_kick),
        .num_i    (div_num),
        .den_i    (max_frequency_setting_i),
        .done_o   (div_done),
        .quot_o   (div_quot)
    );

    always_comb begin
        next_div_kick  = div_done;
        next_div_sel   = div_sel;
        next_freq_frac = freq_frac;
        next_soft_frac = soft_frac;
        if (div_done) begin
            next_div_sel = ~div_sel;
            if (div_sel) begin
                next_soft_frac = div_quot;
            end else begin
                next_freq_frac = div_quot;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_kick  <= 1'b1;
            div_sel   <= 1'b0;
            freq_frac <= '0;
            soft_frac <= '0;
        end else begin
            div_kick  <= next_div_kick;
            div_sel   <= next_div_sel;
            freq_frac <= next_freq_frac;
            soft_frac <= next_soft_frac;
        end
    end

    // ==========================================================
    // Digital monitor duty
    // ==========================================================
    logic [VAL_W-1:0] dig_value;
    logic [VAL_W-1:0] duty;
    logic             pulse_mode;

    always_comb begin
        dig_value = pick_source(digital_monitor_select_i, 1'b1); //RULE_01
    end
    assign pulse_mode = (digital_monitor_select_i == SEL_FREQ_PULSE); //RULE_02

    gain_scaler #(
        .OFS_MUL (NO_OFS_MUL)
    ) u_duty (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .value_i  (dig_value),
        .gain_i   (duty_gain_setting_i),
        .offset_i ('0),
        .scaled_o (duty)
    );

    // ==========================================================
    // PWM frame
    // ==========================================================
    logic [3:0]       tick_cnt;
    logic [3:0]       next_tick_cnt;
    logic             tick;
    logic [VAL_W-1:0] pwm_cnt;
    logic [VAL_W-1:0] next_pwm_cnt;
    logic [VAL_W-1:0] duty_hold;
    logic [VAL_W-1:0] next_duty_hold;
    logic             pwm_level;
    logic             next_pwm_level;

    assign tick = (tick_cnt == PWM_TICK_LAST);

    // The duty is taken only at the start of a frame, so a change of
    // setting never cuts a frame short or doubles its pulse.
    always_comb begin
        next_tick_cnt  = tick ? 4'h0 : tick_cnt + 4'h1;
        next_pwm_cnt   = pwm_cnt;
        next_duty_hold = duty_hold;
        if (tick) begin
            if (pwm_cnt == PWM_CNT_LAST) begin
                next_pwm_cnt   = ZERO_VAL;
                next_duty_hold = duty;
            end else begin
                next_pwm_cnt = pwm_cnt + 10'h001;
            end
        end
        // A frame is 1023 steps, so the full scale code stays high.
        next_pwm_level = (pwm_cnt < duty_hold); //RULE_03
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt  <= '0;
            pwm_cnt   <= '0;
            duty_hold <= '0;
            pwm_level <= 1'b0;
        end else begin
            tick_cnt  <= next_tick_cnt;
            pwm_cnt   <= next_pwm_cnt;
            duty_hold <= next_duty_hold;
            pwm_level <= next_pwm_level;
        end
    end

    // ==========================================================
    // Frequency pulse train
    // ==========================================================
    logic [FREQ_W-1:0]   fm_freq;
    logic [FM_ACC_W-1:0] fm_acc;
    logic [FM_ACC_W-1:0] next_fm_acc;
    logic [FM_ACC_W-1:0] fm_sum;
    logic                fm_level;
    logic                next_fm_level;

    // Above the maximum setting the rate stays at the maximum.
    assign fm_freq = (out_freq_i > max_frequency_setting_i) ?
                     max_frequency_setting_i : out_freq_i; //RULE_06 RULE_11

    // The accumulator makes the rate exact on average, with one
    // clock of jitter per edge instead of a rounded period.
    always_comb begin
        fm_sum        = fm_acc + {18'h00000, fm_freq}; //RULE_05 RULE_07
        next_fm_acc   = fm_sum;
        next_fm_level = fm_level;
        if (!pulse_mode) begin
            next_fm_acc   = '0;
            next_fm_level = 1'b0;
        end else if (fm_sum >= FM_MODULUS) begin
            next_fm_acc   = fm_sum - FM_MODULUS;
            next_fm_level = ~fm_level; //RULE_05
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fm_acc   <= '0;
            fm_level <= 1'b0;
        end else begin
            fm_acc   <= next_fm_acc;
            fm_level <= next_fm_level;
        end
    end

    // ==========================================================
    // Pin and status
    // ==========================================================
    logic pin;
    logic next_pin;
    logic mode;
    logic sel_err;
    logic next_sel_err;

    always_comb begin
        next_pin     = pulse_mode ? fm_level : pwm_level; //RULE_02
        next_sel_err = ~code_ok(digital_monitor_select_i, 1'b1)
                     | ~code_ok(voltage_out_select_i, 1'b0)
                     | ~code_ok(current_out_select_i, 1'b0);
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin     <= 1'b0;
            mode    <= 1'b0;
            sel_err <= 1'b0;
        end else begin
            pin     <= next_pin;
            mode    <= pulse_mode;
            sel_err <= next_sel_err;
        end
    end

    assign digital_monitor_pin_o = pin;
    assign pulse_mode_o          = mode;
    assign select_error_o        = sel_err;

    // ==========================================================
    // Analog monitor channels
    // ==========================================================
    logic [VAL_W-1:0] volt_value;
    logic [VAL_W-1:0] curr_value;

    always_comb begin
        volt_value = pick_source(voltage_out_select_i, 1'b0); //RULE_08
        curr_value = pick_source(current_out_select_i, 1'b0); //RULE_08
    end

    // Code 0 is 0 V and full scale is 10 V on the voltage channel.
    gain_scaler #(
        .OFS_MUL (VOLT_OFS_MUL)
    ) u_volt (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .value_i  (volt_value),
        .gain_i   (voltage_out_gain_i),
        .offset_i (voltage_out_offset_i),
        .scaled_o (voltage_monitor_out_o) //RULE_09
    );

    // Code 0 is 4 mA and full scale is 20 mA on the loop channel, so
    // a broken loop is still told apart from a zero reading.
    gain_scaler #(
        .OFS_MUL (CURR_OFS_MUL)
    ) u_curr (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .value_i  (curr_value),
        .gain_i   (current_out_gain_i),
        .offset_i (current_out_offset_i),
        .scaled_o (current_loop_out_o) //RULE_09
    );

endmodule

// ### verilog/frac_divider.sv
`timescale 1ns/100ps

module frac_divider
    import monitor_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic              start_i,
    input  wire logic [FREQ_W-1:0] num_i,
    input  wire logic [FREQ_W-1:0] den_i,
    output logic                   done_o,
    output logic [VAL_W-1:0]       quot_o
);

    typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} div_state_t;

    div_state_t        state;
    div_state_t        next_state;
    logic [FREQ_W:0]   rem;
    logic [FREQ_W:0]   next_rem;
    logic [FREQ_W-1:0] den;
    logic [FREQ_W-1:0] next_den;
    logic [VAL_W-1:0]  quot;
    logic [VAL_W-1:0]  next_quot;
    logic [3:0]        step;
    logic [3:0]        next_step;
    logic              done;
    logic              next_done;
    logic [FREQ_W+1:0] trial;

    // ==========================================================
    // Restoring division of num * 1024 / den
    // ==========================================================
    always_comb begin
        next_state = state;
        next_rem   = rem;
        next_den   = den;
        next_quot  = quot;
        next_step  = step;
        next_done  = 1'b0;
        trial      = {rem, 1'b0};
        case (state)
            DIV_IDLE: begin
                if (start_i) begin
                    // A ratio of one or more cannot be shown; pin it.
                    if (num_i >= den_i) begin
                        next_quot = FULL_SCALE; //RULE_11
                        next_done = 1'b1;
                    end else begin
                        next_rem   = {1'b0, num_i};
                        next_den   = den_i;
                        next_quot  = ZERO_VAL;
                        next_step  = DIV_STEPS;
                        next_state = DIV_RUN;
                    end
                end
            end
            DIV_RUN: begin
                if (trial >= {2'b00, den}) begin
                    next_rem  = 17'(trial - {2'b00, den});
                    next_quot = {quot[VAL_W-2:0], 1'b1};
                end else begin
                    next_rem  = trial[FREQ_W:0];
                    next_quot = {quot[VAL_W-2:0], 1'b0};
                end
                next_step = step - 4'h1;
                if (step == 4'h1) begin
                    next_done  = 1'b1;
                    next_state = DIV_IDLE;
                end
            end
            default: begin
                next_state = DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= DIV_IDLE;
            rem   <= '0;
            den   <= '0;
            quot  <= '0;
            step  <= '0;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            rem   <= next_rem;
            den   <= next_den;
            quot  <= next_quot;
            step  <= next_step;
            done  <= next_done;
        end
    end

    assign done_o = done;
    assign quot_o = quot;

endmodule

// ### verilog/gain_scaler.sv
`timescale 1ns/100ps

module gain_scaler
    import monitor_pkg::*;
#(
    parameter logic [10:0] OFS_MUL = NO_OFS_MUL
)
(
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic [VAL_W-1:0]  value_i,
    input  wire logic [GAIN_W-1:0] gain_i,
    input  wire logic [OFS_W-1:0]  offset_i,
    output logic [VAL_W-1:0]       scaled_o
);

    logic [17:0]      prod;
    logic [18:0]      ofs_full;
    logic [13:0]      sum;
    logic [VAL_W-1:0] scaled;
    logic [VAL_W-1:0] next_scaled;

    // ==========================================================
    // Gain, offset and saturation
    // ==========================================================
    always_comb begin
        prod     = value_i * gain_i; //RULE_04 RULE_10
        ofs_full = offset_i * OFS_MUL; //RULE_10
        sum      = {3'b000, prod[17:GAIN_SHIFT]}
                 + {1'b0, ofs_full[18:OFS_SHIFT]};
        // Clipping keeps an overdriven meter at its stop instead of
        // letting the reading wrap back towards zero.
        if (sum > {4'h0, FULL_SCALE}) begin
            next_scaled = FULL_SCALE; //RULE_11
        end else begin
            next_scaled = sum[VAL_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scaled <= '0;
        end else begin
            scaled <= next_scaled;
        end
    end

    assign scaled_o = scaled;

endmodule
